// ### low_power_mode_and_driver_shutdown_tb_top.sv
// Self-checking bench for the low-power and driver-kill sequencer.
// Assumes lps_pkg, lps_ctrl and lps_host_model are compiled before this file.
`default_nettype none
module low_power_mode_and_driver_shutdown_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] mode;
        logic sel;
        logic [1:0] prof;
        logic wake;
        logic [15:0] v;
        logic [15:0] refp;
        logic [1:0] st;
    } lps_row_t;
    localparam logic [1:0] st_act = lps_pkg::LPS_ACTIVE;
    localparam logic [1:0] st_sb = lps_pkg::LPS_STANDBY;
    localparam logic [1:0] st_sl = lps_pkg::LPS_SLEEP;
    localparam logic [1:0] st_flt = lps_pkg::LPS_FAULT;
    localparam logic [1:0] m_ana = lps_pkg::LPS_IN_ANALOG;
    localparam logic [1:0] m_pwm = lps_pkg::LPS_IN_PWM;
    localparam logic [1:0] m_frq = lps_pkg::LPS_IN_FREQ;
    localparam logic [1:0] m_reg = lps_pkg::LPS_IN_REG;
    localparam logic [15:0] hi = 16'h1000;
    localparam logic [15:0] rp = 16'h0100;
    // Hysteresis 2% and limits of 1000 give thresholds 0x28F (register, duty),
    // 0x51 (analog), 0x14 (frequency) and 0x0A (shaped profile).
    localparam lps_row_t rows [21] = '{
        '{m_reg, 1'h0, 2'h0, 1'h1, hi, rp, st_act},
        '{m_reg, 1'h0, 2'h0, 1'h0, hi, rp, st_sb},
        '{m_reg, 1'h0, 2'h0, 1'h1, 16'h028F, rp, st_sb},
        '{m_reg, 1'h0, 2'h0, 1'h1, 16'h0290, rp, st_act},
        '{m_reg, 1'h0, 2'h0, 1'h1, 16'h028F, rp, st_act},
        '{m_reg, 1'h0, 2'h0, 1'h1, 16'h028E, rp, st_sb},
        '{m_reg, 1'h0, 2'h0, 1'h1, hi, rp, st_act},
        '{m_pwm, 1'h0, 2'h0, 1'h1, 16'h028E, rp, st_sb},
        '{m_pwm, 1'h0, 2'h0, 1'h1, 16'h0290, rp, st_act},
        '{m_frq, 1'h0, 2'h0, 1'h1, 16'h0013, rp, st_sb},
        '{m_frq, 1'h0, 2'h0, 1'h1, 16'h0015, rp, st_act},
        '{m_ana, 1'h0, 2'h0, 1'h1, 16'h0050, rp, st_sb},
        '{m_ana, 1'h0, 2'h0, 1'h1, 16'h0052, rp, st_act},
        '{m_ana, 1'h0, 2'h1, 1'h1, 16'h0009, rp, st_sb},
        '{m_ana, 1'h0, 2'h1, 1'h1, 16'h000B, rp, st_act},
        '{m_reg, 1'h0, 2'h0, 1'h1, hi, 16'h0000, st_sb},
        '{m_reg, 1'h0, 2'h0, 1'h1, hi, rp, st_act},
        '{m_ana, 1'h1, 2'h0, 1'h1, 16'h0050, rp, st_sl},
        '{m_ana, 1'h1, 2'h0, 1'h1, hi, rp, st_act},
        '{m_reg, 1'h1, 2'h0, 1'h0, hi, rp, st_sl},
        '{m_reg, 1'h1, 2'h0, 1'h1, hi, rp, st_act}
    };
    logic i_clk = 1'h0;
    logic i_rstn = 1'h0;
    logic wake_req = 1'h1, kill_req = 1'h0, clear_req = 1'h0;
    logic wake_pin, kill_pin, fault_clear;
    logic low_power_select = 1'h0;
    logic [1:0] ref_mode = 2'h3;
    logic [1:0] profile_select = 2'h0;
    logic [1:0] entry_time = 2'h0;
    logic [6:0] hysteresis = 7'h02;
    logic [15:0] meas = 16'h1000;
    logic [15:0] ref_profiled = 16'h0100;
    logic regs_ready = 1'h0, fault_event = 1'h0, fault_active = 1'h0;
    logic gate_en, gs_en, ldo_en, csa_en, ser_en, act_pd, pas_pd, kill_st, start, fault_n;
    logic [1:0] state;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    int cnt;
    lps_row_t r;

    lps_host_model lps_host_model_i (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_wake_req(wake_req), .i_kill_req(kill_req),
        .i_clear_req(clear_req), .o_wake_pin(wake_pin), .o_kill_pin(kill_pin),
        .o_fault_clear(fault_clear)
    );
    // Detect times of zero keep the run short; the threshold logic is unchanged.
    lps_ctrl #(.ANA_DET_MS(0), .PWM_SL_DET_MS(0), .WAKE_DET_MS(0)) lps_ctrl_i (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_wake_pin(wake_pin),
        .i_driver_kill_pin(kill_pin), .i_low_power_select(low_power_select),
        .i_ref_mode(ref_mode), .i_sleep_entry_time(entry_time), .i_profile_select(profile_select),
        .i_input_hysteresis(hysteresis), .i_wake_level(meas), .i_duty(meas), .i_freq(meas),
        .i_max_freq(16'h03E8), .i_speed_cmd(meas), .i_ctrl_limit(16'h03E8),
        .i_ref_profiled(ref_profiled), .i_regs_ready(regs_ready),
        .i_fault_event(fault_event), .i_fault_active(fault_active),
        .i_fault_clear(fault_clear), .o_gate_enable(gate_en),
        .o_gate_supply_regulator_en(gs_en), .o_analog_ldo_en(ldo_en), .o_csa_en(csa_en),
        .o_serial_en(ser_en), .o_active_pulldown(act_pd), .o_passive_pulldown(pas_pd),
        .o_driver_kill_status(kill_st), .o_motor_start(start), .o_fault_out_n(fault_n),
        .o_state(state)
    );

    always #20 i_clk = ~i_clk;

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Sampling 1 ns past the edge lets that edge's register updates land first.
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic clear_fault();
        @(posedge i_clk);
        clear_req <= 1'h1;
        @(posedge i_clk);
        clear_req <= 1'h0;
        settle(3);
    endtask

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            $display("timeout after %0d cycles", cycles);
            end_of_test();
        end
    end

    initial begin
        settle(11);
        chk("fault_out_n in reset", fault_n, 1'h0);
        @(posedge i_clk);
        i_rstn <= 1'h1;
        settle(2);
        chk("state after reset", state, st_act);
        settle(4);
        chk("fault_out_n regs off", fault_n, 1'h0);
        @(posedge i_clk);
        regs_ready <= 1'h1;
        settle(3);
        chk("fault_out_n regs on", fault_n, 1'h1);
        $display("test reset done");
        foreach (rows[k]) begin
            r = rows[k];
            @(posedge i_clk);
            ref_mode <= r.mode;
            low_power_select <= r.sel;
            profile_select <= r.prof;
            wake_req <= r.wake;
            meas <= r.v;
            ref_profiled <= r.refp;
            settle(10);
            chk("state", state, r.st);
            chk("rails", {gs_en, ldo_en, csa_en, ser_en}, (r.st == st_sl) ? 4'h0 : 4'hF);
            if (r.st == st_sl) begin
                chk("gate in sleep", gate_en, 1'h0);
            end
        end
        $display("test state table done");
        // Zero hysteresis must fall back to the 1% floor: 0x147 on the register scale.
        @(posedge i_clk);
        low_power_select <= 1'h0;
        hysteresis <= 7'h00;
        meas <= 16'h0146;
        settle(10);
        chk("floor entry", state, st_sb);
        @(posedge i_clk);
        meas <= 16'h0148;
        settle(10);
        chk("floor exit", state, st_act);
        @(posedge i_clk);
        ref_mode <= m_ana;
        low_power_select <= 1'h1;
        entry_time <= 2'h2;
        hysteresis <= 7'h02;
        meas <= 16'h0050;
        settle(10);
        chk("slow analog entry", state, st_sl);
        @(posedge i_clk);
        meas <= hi;
        settle(10);
        chk("analog wake", state, st_act);
        $display("test threshold floor done");
        @(posedge i_clk);
        fault_event <= 1'h1;
        @(posedge i_clk);
        fault_event <= 1'h0;
        fault_active <= 1'h1;
        settle(2);
        chk("fault state", state, st_flt);
        chk("fault_out_n in fault", fault_n, 1'h0);
        chk("gate in fault", gate_en, 1'h0);
        clear_fault();
        chk("clear while condition present", state, st_flt);
        @(posedge i_clk);
        fault_active <= 1'h0;
        clear_fault();
        chk("state after clear", state, st_act);
        chk("fault_out_n after clear", fault_n, 1'h1);
        $display("test fault latch done");
        @(posedge i_clk);
        kill_req <= 1'h1;
        #1;
        chk("gate before kill pin", gate_en, 1'h1);
        settle(1);
        chk("gate at kill pin", gate_en, 1'h0);
        cnt = 0;
        for (int k = 0; k < 100 && pas_pd !== 1'h1; k++) begin
            settle(1);
            cnt += (act_pd === 1'h1);
        end
        chk("active pull-down span", cnt[15:0], 16'h0032);
        chk("passive pull-down", {act_pd, pas_pd}, 2'h1);
        chk("kill status high", kill_st, 1'h1);
        chk("state under kill", state, st_act);
        chk("fault_out_n under kill", fault_n, 1'h1);
        @(posedge i_clk);
        kill_req <= 1'h0;
        cnt = 0;
        repeat (12) begin
            settle(1);
            cnt += (start === 1'h1);
        end
        chk("motor start pulses", cnt[15:0], 16'h0001);
        chk("kill status low", kill_st, 1'h0);
        $display("test driver kill done");
        end_of_test();
    end
endmodule // low_power_mode_and_driver_shutdown_tb_top
`default_nettype wire

// ### lps_cfg.svh
// Constants for the low-power and driver-shutdown sequencer.
// Assumes a 25 MHz core clock; lps_ctrl includes this by bare name.
`ifndef LPS_CFG_SVH
`define LPS_CFG_SVH
`define LPS_CLK_HZ 25000000
`define LPS_ANA_FS 16'h0FFF
`define LPS_REG_FS 16'h7FFF
`define LPS_FREQ_FLOOR 16'h0003
`define LPS_MIN_PCT 7'h01
`define LPS_PCT_DIV 32'h00000064
`define LPS_ANA_DET_MS 1
`define LPS_PWM_SL_DET_MS 20
`define LPS_WAKE_DET_MS 1
`define LPS_SINK_NS 2000
`define LPS_SEL_SLEEP 1'h1
`define LPS_PROF_DIRECT 2'h0
`endif

// ### lps_ctrl.sv
// Operating-state sequencer: sleep/standby entry and exit, fault latch,
// fault output and the external driver-kill shutdown path.
// Assumes measured levels, duty, frequency and commands are on i_clk;
// the wake and driver-kill pins are asynchronous.
// Operation
// - Sleep turns off gate drivers, gate supply, analog LDO, sense amp, serial port.
// - Low-power select 1 picks sleep, 0 picks standby.
// - Analog sleep entry: level below threshold for analog or PWM detect time.
// - PWM duty below/above thresholds for detect times enters/leaves standby.
// - Frequency below/above thresholds for detect times enters/leaves standby.
// - Register mode leaves standby only with wake high and command above threshold.
// - Register mode: wake low forces standby (sleep with low-power select 1) whatever the command.
// - Standby keeps gate supply, analog LDO and serial port powered.
// - Standby is entered whenever the profiled reference is zero with low-power select 0.
// - Direct profile: threshold is max(1%, hysteresis) of the mode's full scale; frequency mode floors it at LPS_FREQ_FLOOR.
// - Shaped profile: threshold is 1% of the controlled quantity's limit.
// - Fault output held low while regulators are off, released after.
// - Latched fault holds partial shutdown until condition gone and clear written.
// - Kill pin high turns the gate driver off directly, bypassing logic.
// - Kill shutdown: active pull-down for sink time, then passive pull-down.
// - Kill pin never causes sleep or standby; core stays active.
// - Kill status mirrors the pin within 200 ms.
// - Kill pin is not reported on the fault output; motor faults still are.
// - Kill pin falling starts the motor start sequence within 200 ms.
`default_nettype none
`include "lps_cfg.svh"
module lps_ctrl #(
    parameter int ANA_DET_MS = `LPS_ANA_DET_MS,
    parameter int PWM_SL_DET_MS = `LPS_PWM_SL_DET_MS,
    parameter int WAKE_DET_MS = `LPS_WAKE_DET_MS
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_wake_pin,
    input wire logic i_driver_kill_pin,
    input wire logic i_low_power_select,
    input wire logic [1:0] i_ref_mode,
    input wire logic [1:0] i_sleep_entry_time,
    input wire logic [1:0] i_profile_select,
    input wire logic [6:0] i_input_hysteresis,
    input wire logic [15:0] i_wake_level,
    input wire logic [15:0] i_duty,
    input wire logic [15:0] i_freq,
    input wire logic [15:0] i_max_freq,
    input wire logic [15:0] i_speed_cmd,
    input wire logic [15:0] i_ctrl_limit,
    input wire logic [15:0] i_ref_profiled,
    input wire logic i_regs_ready,
    input wire logic i_fault_event,
    input wire logic i_fault_active,
    input wire logic i_fault_clear,
    output logic o_gate_enable,
    output logic o_gate_supply_regulator_en,
    output logic o_analog_ldo_en,
    output logic o_csa_en,
    output logic o_serial_en,
    output logic o_active_pulldown,
    output logic o_passive_pulldown,
    output logic o_driver_kill_status,
    output logic o_motor_start,
    output logic o_fault_out_n,
    output logic [1:0] o_state
);
    localparam logic [31:0] ANA_CYC = 32'(ANA_DET_MS * (`LPS_CLK_HZ / 1000));
    localparam logic [31:0] PWM_SL_CYC = 32'(PWM_SL_DET_MS * (`LPS_CLK_HZ / 1000));
    localparam logic [31:0] WAKE_CYC = 32'(WAKE_DET_MS * (`LPS_CLK_HZ / 1000));
    // Least time: round up to whole cycles.
    localparam int SINK_CYC_I = (`LPS_SINK_NS * (`LPS_CLK_HZ / 1000000) + 999) / 1000;
    localparam logic [7:0] SINK_CYC = 8'(SINK_CYC_I);

    typedef struct packed {
        lps_pkg::lps_state_t st;
        logic latch;
        logic [7:0] sink_cnt;
        logic kill_st;
        logic start;
        logic fault_n;
        logic gate_en;
        logic gs_en;
        logic ldo_en;
        logic csa_en;
        logic ser_en;
        logic apd;
        logic ppd;
    } lps_ctrl_st_t;
    lps_ctrl_st_t r, n;

    logic [1:0] sync_lvl;
    logic wake_s, kill_s;
    logic ent_cond, ext_cond, ent_met, ext_met;
    logic [31:0] ent_lim, ext_lim;
    logic [15:0] thr, meas;
    logic [6:0] pct;
    logic below, above, ref_zero;
    lps_pkg::lps_ref_mode_t mode;

    // The wake pin idles high and the kill pin idles low.
    lps_sync #(.W(2), .RST_LVL(2'h1)) u_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_pin({i_driver_kill_pin, i_wake_pin}),
        .o_level(sync_lvl)
    );
    assign wake_s = sync_lvl[0];
    assign kill_s = sync_lvl[1];

    // Percentage of a full-scale value; used for every threshold flavour.
    function automatic logic [15:0] pct_of(input logic [15:0] fs, input logic [6:0] p);
        logic [31:0] prod;
        prod = 32'(fs) * 32'(p) / `LPS_PCT_DIV;
        return prod[15:0];
    endfunction

    always_comb begin
        mode = lps_pkg::lps_ref_mode_t'(i_ref_mode);
        pct = (i_input_hysteresis > `LPS_MIN_PCT) ? i_input_hysteresis : `LPS_MIN_PCT;
        thr = '0;
        meas = i_wake_level;
        if (i_profile_select != `LPS_PROF_DIRECT) begin
            thr = pct_of(i_ctrl_limit, `LPS_MIN_PCT);
        end
        case (mode)
            lps_pkg::LPS_IN_ANALOG: begin
                meas = i_wake_level;
                if (i_profile_select == `LPS_PROF_DIRECT) thr = pct_of(`LPS_ANA_FS, pct);
            end
            lps_pkg::LPS_IN_PWM: begin
                meas = i_duty;
                if (i_profile_select == `LPS_PROF_DIRECT) thr = pct_of(`LPS_REG_FS, pct);
            end
            lps_pkg::LPS_IN_FREQ: begin
                meas = i_freq;
                if (i_profile_select == `LPS_PROF_DIRECT) begin
                    thr = pct_of(i_max_freq, pct);
                    if (thr < `LPS_FREQ_FLOOR) thr = `LPS_FREQ_FLOOR;
                end
            end
            default: begin
                meas = i_speed_cmd;
                if (i_profile_select == `LPS_PROF_DIRECT) thr = pct_of(`LPS_REG_FS, pct);
            end
        endcase
    end

    assign below = meas < thr;
    assign above = meas > thr;
    assign ref_zero = (i_ref_profiled == '0);

    // Entry is only watched while active, exit only while resting, so a
    // single pair of timers covers every mode.
    always_comb begin
        ent_cond = 1'b0;
        ent_lim = '0;
        ext_cond = 1'b0;
        ext_lim = '0;
        if (i_low_power_select == `LPS_SEL_SLEEP) begin
            case (mode)
                lps_pkg::LPS_IN_ANALOG: begin
                    ent_cond = below;
                    ent_lim = i_sleep_entry_time[1] ? PWM_SL_CYC : ANA_CYC;
                end
                lps_pkg::LPS_IN_REG: ent_cond = !wake_s;
                default: begin
                    ent_cond = !wake_s;
                    ent_lim = PWM_SL_CYC;
                end
            endcase
        end else begin
            case (mode)
                lps_pkg::LPS_IN_ANALOG: ent_cond = below;
                lps_pkg::LPS_IN_REG: ent_cond = !wake_s || below;
                default: begin
                    ent_cond = below;
                    ent_lim = PWM_SL_CYC;
                end
            endcase
            if (ref_zero) begin
                ent_cond = 1'b1;
                ent_lim = '0;
            end
        end
        if (r.st == lps_pkg::LPS_SLEEP) begin
            case (mode)
                lps_pkg::LPS_IN_ANALOG: ext_cond = above;
                lps_pkg::LPS_IN_REG: ext_cond = wake_s;
                default: begin
                    ext_cond = wake_s;
                    ext_lim = WAKE_CYC;
                end
            endcase
        end else if (r.st == lps_pkg::LPS_STANDBY) begin
            case (mode)
                lps_pkg::LPS_IN_ANALOG: ext_cond = above;
                lps_pkg::LPS_IN_REG: ext_cond = wake_s && above;
                default: begin
                    ext_cond = above;
                    ext_lim = WAKE_CYC;
                end
            endcase
            // A zero reference holds standby; otherwise the block would leave
            // and re-enter it on alternate cycles.
            if (ref_zero) ext_cond = 1'b0;
        end
        if (r.st != lps_pkg::LPS_ACTIVE) ent_cond = 1'b0;
    end

    lps_qual #(.CW(32)) u_ent (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_cond(ent_cond),
        .i_limit(ent_lim),
        .o_met(ent_met)
    );
    lps_qual #(.CW(32)) u_ext (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_cond(ext_cond),
        .i_limit(ext_lim),
        .o_met(ext_met)
    );

    always_comb begin
        n = r;
        // A new fault outranks a clear arriving in the same cycle.
        n.latch = i_fault_event || (r.latch && !(i_fault_clear && !i_fault_active));
        case (r.st)
            lps_pkg::LPS_ACTIVE: begin
                if (n.latch) begin
                    n.st = lps_pkg::LPS_FAULT;
                end else if (ent_met) begin
                    n.st = (i_low_power_select == `LPS_SEL_SLEEP) ? lps_pkg::LPS_SLEEP
                                                                   : lps_pkg::LPS_STANDBY;
                end
            end
            lps_pkg::LPS_STANDBY: if (ext_met) n.st = lps_pkg::LPS_ACTIVE;
            lps_pkg::LPS_SLEEP: if (ext_met) n.st = lps_pkg::LPS_ACTIVE;
            default: if (!n.latch) n.st = lps_pkg::LPS_ACTIVE;
        endcase
        // The kill pin takes no part in the state choice above.
        n.gate_en = (n.st == lps_pkg::LPS_ACTIVE);
        n.gs_en = (n.st != lps_pkg::LPS_SLEEP);
        n.ldo_en = (n.st != lps_pkg::LPS_SLEEP);
        n.csa_en = (n.st != lps_pkg::LPS_SLEEP);
        n.ser_en = (n.st != lps_pkg::LPS_SLEEP);
        n.fault_n = i_regs_ready && !n.latch;
        n.kill_st = kill_s;
        n.start = r.kill_st && !kill_s;
        if (!kill_s) begin
            n.sink_cnt = '0;
        end else if (r.sink_cnt < SINK_CYC) begin
            n.sink_cnt = r.sink_cnt + 8'h01;
        end
        // Comparing the count held before this edge gives exactly SINK_CYC active cycles.
        n.apd = kill_s && (r.sink_cnt < SINK_CYC);
        n.ppd = kill_s && (r.sink_cnt >= SINK_CYC);
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // The raw pin gates the driver so an external monitor does not wait on
    // the synchroniser; the pull-down sequencing follows a few cycles later.
    assign o_gate_enable = r.gate_en && !i_driver_kill_pin;
    assign o_gate_supply_regulator_en = r.gs_en;
    assign o_analog_ldo_en = r.ldo_en;
    assign o_csa_en = r.csa_en;
    assign o_serial_en = r.ser_en;
    assign o_active_pulldown = r.apd;
    assign o_passive_pulldown = r.ppd;
    assign o_driver_kill_status = r.kill_st;
    assign o_motor_start = r.start;
    assign o_fault_out_n = r.fault_n;
    assign o_state = r.st;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    a_sleep_rails_off: assert property (r.st == lps_pkg::LPS_SLEEP |->
        !o_gate_enable && !o_gate_supply_regulator_en && !o_analog_ldo_en
        && !o_csa_en && !o_serial_en) else $error("Sleep left a rail on.");
    a_lp_kind_sel: assert property ($past(r.st) == lps_pkg::LPS_ACTIVE
        && r.st inside {lps_pkg::LPS_SLEEP, lps_pkg::LPS_STANDBY}
        |-> (r.st == lps_pkg::LPS_SLEEP) == $past(i_low_power_select))
        else $error("Wrong low-power state chosen.");
    a_standby_rails_on: assert property (r.st == lps_pkg::LPS_STANDBY |->
        o_gate_supply_regulator_en && o_analog_ldo_en && o_serial_en)
        else $error("Standby dropped a rail.");
    a_reg_wake_low: assert property (r.st == lps_pkg::LPS_ACTIVE && !r.latch
        && !i_fault_event && !i_low_power_select && mode == lps_pkg::LPS_IN_REG
        && !wake_s |=> r.st == lps_pkg::LPS_STANDBY) else $error("Wake low ignored.");
    a_ref_zero_sb: assert property (r.st == lps_pkg::LPS_ACTIVE && !r.latch
        && !i_fault_event && !i_low_power_select && ref_zero
        |=> r.st == lps_pkg::LPS_STANDBY) else $error("Zero reference ignored.");
    a_reg_exit_wake: assert property ($past(r.st) == lps_pkg::LPS_STANDBY
        && r.st == lps_pkg::LPS_ACTIVE && $past(mode) == lps_pkg::LPS_IN_REG
        |-> $past(wake_s) && $past(above)) else $error("Early register wake.");
    a_fault_holds: assert property (r.st == lps_pkg::LPS_FAULT
        && !(i_fault_clear && !i_fault_active) |=> r.st == lps_pkg::LPS_FAULT)
        else $error("Fault released without clear.");
    a_fault_pwrup: assert property (!i_regs_ready |=> !o_fault_out_n)
        else $error("Fault output released with regulators off.");
    a_kill_gate: assert property (i_driver_kill_pin |-> !o_gate_enable)
        else $error("Gate on with kill pin high.");
    a_sink_time: assert property ($rose(o_passive_pulldown) |->
        $past(o_active_pulldown) && r.sink_cnt == SINK_CYC && !o_active_pulldown)
        else $error("Pull-down order or time wrong.");
    a_kill_status: assert property (i_driver_kill_pin[*6] |-> o_driver_kill_status)
        else $error("Kill status late.");
    a_kill_no_lp: assert property (r.st == lps_pkg::LPS_ACTIVE && !ent_met
        && !n.latch |=> r.st == lps_pkg::LPS_ACTIVE) else $error("Left active unasked.");
    a_restart: assert property ($fell(o_driver_kill_status) |-> o_motor_start)
        else $error("No start after kill release.");

    c_sleep: cover property ($rose(r.st == lps_pkg::LPS_SLEEP));
    c_standby: cover property ($rose(r.st == lps_pkg::LPS_STANDBY));
    c_fault_rec: cover property (r.st == lps_pkg::LPS_FAULT ##1 r.st == lps_pkg::LPS_ACTIVE);
    c_kill_seq: cover property ($rose(o_passive_pulldown));
endmodule // lps_ctrl
`default_nettype wire

// ### lps_host_model.sv
// Host-side model: drives the wake pin, the driver-kill pin and the clear-fault write.
// Assumes the bench raises its requests just after a rising edge of i_clk.
`default_nettype none
module lps_host_model (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_wake_req,
    input wire logic i_kill_req,
    input wire logic i_clear_req,
    output logic o_wake_pin,
    output logic o_kill_pin,
    output logic o_fault_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clear_req_r;
    // Pins move only after an edge, as a real controller's port register would.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_wake_pin <= 1'h1;
            o_kill_pin <= 1'h0;
            o_fault_clear <= 1'h0;
            clear_req_r <= 1'h0;
        end else begin
            o_wake_pin <= i_wake_req;
            o_kill_pin <= i_kill_req;
            clear_req_r <= i_clear_req;
            // A held request still writes the clear bit only once.
            o_fault_clear <= i_clear_req & ~clear_req_r;
        end
    end
endmodule // lps_host_model
`default_nettype wire

// ### lps_pkg.sv
// Types shared by the sequencer modules.
// Assumes lps_cfg.svh holds all numeric constants.
`default_nettype none
package lps_pkg;
    typedef enum logic [1:0] {
        LPS_ACTIVE = 2'h0,
        LPS_STANDBY = 2'h1,
        LPS_SLEEP = 2'h3,
        LPS_FAULT = 2'h2
    } lps_state_t;
    typedef enum logic [1:0] {
        LPS_IN_ANALOG = 2'h0,
        LPS_IN_PWM = 2'h1,
        LPS_IN_FREQ = 2'h2,
        LPS_IN_REG = 2'h3
    } lps_ref_mode_t;
endpackage
`default_nettype wire

// ### lps_qual.sv
// Qualification timer: flags a condition that has held for i_limit cycles.
// Assumes i_cond and i_limit are synchronous to i_clk.
`default_nettype none
module lps_qual #(
    parameter int CW = 32
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_cond,
    input wire logic [CW-1:0] i_limit,
    output logic o_met
);
    typedef struct packed {
        logic [CW-1:0] cnt;
    } lps_qual_st_t;
    lps_qual_st_t r, n;

    always_comb begin
        n = r;
        if (!i_cond) begin
            n.cnt = '0;
        end else if (r.cnt < i_limit) begin
            n.cnt = r.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // A zero limit qualifies at once, which the immediate table entries rely on.
    assign o_met = i_cond && (r.cnt >= i_limit);
endmodule // lps_qual
`default_nettype wire

// ### lps_sync.sv
// Three-stage input synchroniser with agreement filter for pin inputs.
// Assumes the inputs are asynchronous to i_clk.
`default_nettype none
module lps_sync #(
    parameter int W = 2,
    parameter logic [W-1:0] RST_LVL = '0
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_level
);
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] lvl;
    } lps_sync_st_t;
    lps_sync_st_t r, n;

    // A change is accepted only once stages two and three agree.
    always_comb begin
        n = r;
        n.ff1 = i_pin;
        n.ff2 = r.ff1;
        n.ff3 = r.ff2;
        for (int i = 0; i < W; i++) begin
            if (r.ff2[i] == r.ff3[i]) begin
                n.lvl[i] = r.ff3[i];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            // Stages start at each pin's idle level, so no false edge follows reset.
            r <= '{ff1: RST_LVL, ff2: RST_LVL, ff3: RST_LVL, lvl: RST_LVL};
        end else begin
            r <= n;
        end
    end

    assign o_level = r.lvl;
endmodule // lps_sync
`default_nettype wire
